// [include/mac_host_pkg.sv]
/*
 * Constants, field positions and carrier types for the Ethernet MAC
 * control register block and its 16-bit host access adapter.
 * Assumes a byte-addressed host bus with a 20-bit address.
 */
package mac_host_pkg;

    // MAC register page: base 0x72000, address bits [19:8]
    localparam logic [11:0] MAC_BASE_PAGE   = 12'h720;

    localparam logic [7:0]  OFF_CONTROL     = 8'h00;
    localparam logic [7:0]  OFF_CONFIG      = 8'h04;
    localparam logic [7:0]  OFF_LINK_STATUS = 8'h08;
    localparam logic [7:0]  OFF_TX_STATUS   = 8'h14;
    localparam logic [7:0]  OFF_IRQ_STATUS  = 8'h24;
    localparam logic [7:0]  OFF_IRQ_EN_SET  = 8'h28;
    localparam logic [7:0]  OFF_IRQ_EN_CLR  = 8'h2C;
    localparam logic [7:0]  OFF_IRQ_MASK    = 8'h30;
    localparam logic [7:0]  OFF_PHY_SHIFT   = 8'h34;
    localparam logic [7:0]  OFF_PAUSE_TIMER = 8'h38;
    localparam logic [7:0]  OFF_ADDR_LOW    = 8'h98;
    localparam logic [7:0]  OFF_ADDR_HIGH   = 8'h9C;
    localparam logic [7:0]  OFF_PAUSE_QUANT = 8'hBC;
    localparam logic [7:0]  OFF_SMII_STATUS = 8'hC0;

    // control register fields
    localparam int CTL_ZERO_PAUSE = 12;
    localparam int CTL_PAUSE      = 11;
    localparam int CTL_BACKPRESS  = 8;
    localparam int CTL_STATS_WE   = 7;
    localparam int CTL_STATS_INC  = 6;
    localparam int CTL_STATS_CLR  = 5;
    localparam int CTL_MGMT_EN    = 4;
    localparam int CTL_TX_EN      = 3;
    localparam int CTL_RX_EN      = 2;
    localparam logic [31:0] CTL_STORED_MASK = 32'h0000_019C;
    localparam logic [31:0] CTL_RESET       = 32'h0000_0000;

    // configuration register fields
    localparam logic [31:0] CFG_MASK        = 32'h000D_3D13;
    localparam logic [31:0] CFG_RESET       = 32'h0000_0800;
    localparam int CFG_FULL_DUPLEX = 1;
    localparam int CFG_MDC_LO      = 10;

    localparam int LINK_PHY_IDLE   = 2;

    // transmit status, write one to clear
    localparam logic [31:0] TXS_MASK        = 32'h0000_0046;
    localparam int TXS_UNDERRUN = 6;
    localparam int TXS_RETRY    = 2;
    localparam int TXS_COLLIDE  = 1;

    // interrupt status / mask fields
    localparam logic [13:0] IRQ_BITS        = 14'h3031;
    localparam logic [13:0] IRQ_MASK_RESET  = 14'h3031;
    localparam int IRQ_PAUSE_ZERO = 13;
    localparam int IRQ_PAUSE_RXD  = 12;
    localparam int IRQ_RETRY      = 5;
    localparam int IRQ_UNDERRUN   = 4;
    localparam int IRQ_MGMT_DONE  = 0;

    // management shift timing
    localparam logic [1:0] PHY_OP_READ      = 2'h2;
    localparam logic [5:0] PHY_TURN_BIT     = 6'h0E;
    localparam logic [5:0] PHY_LAST_BIT     = 6'h1F;
    localparam logic [7:0] MDC_HALF_BASE    = 8'h04;

    typedef enum logic [1:0] {
        MG_IDLE  = 2'b01,
        MG_SHIFT = 2'b10
    } mgmt_state_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [19:0] addr;
        logic [31:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  off;
        logic [31:0] wdata;
    } reg_acc_t;

endpackage

// [src/half_word_access.sv]
/*
 * Splits 16-bit host accesses to wide MAC elements into a latched
 * two-step read and write; passes every other access straight on.
 * Assumes the request and the full read value are on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module half_word_access (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  mode16,
    input  wire logic                  wide,
    input  wire mac_host_pkg::host_req_t req,
    input  wire logic [31:0]           rdata_full,
    output var  mac_host_pkg::reg_acc_t  acc,
    output logic [31:0]                rdata_bus
);
    logic [15:0] wr_low_reg;
    logic [31:0] rd_hold_reg;
    wire         split;
    wire         upper_step;

    // two steps only for wide elements in 16-bit mode
    assign split      = mode16 & wide;
    assign upper_step = split & req.addr[1];

    // first write step only latches, second commits all
    assign acc.wr    = req.wr & ~upper_step;
    assign acc.rd    = req.rd & ~(split & ~req.addr[1]);
    assign acc.off   = {req.addr[7:2], 2'b00};
    assign acc.wdata = split  ? {req.wdata[15:0], wr_low_reg} :
                       mode16 ? {16'h0000, req.wdata[15:0]} : req.wdata;

    // low half now, latched upper half next
    assign rdata_bus = !mode16   ? rdata_full :
                       !split    ? {16'h0000, rdata_full[15:0]} :
                       upper_step ? {16'h0000, rdata_full[15:0]} :
                                    {16'h0000, rd_hold_reg[31:16]};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_low_reg  <= 16'h0000;
            rd_hold_reg <= 32'h0000_0000;
        end else begin
            if (req.wr && upper_step)
                wr_low_reg <= req.wdata[15:0];
            if (req.rd && upper_step)
                rd_hold_reg <= rdata_full;
        end
    end
endmodule // half_word_access
`default_nettype wire

// [src/mac_control_host.sv]
/*
 * Ethernet MAC control, configuration and status registers behind the
 * host parallel bus, with pause requests, back pressure, statistics
 * commands and the PHY management shift register.
 * Assumes host strobes are one-cycle pulses on CLK; mode strap and
 * MDIO pin are asynchronous and are synchronised here.
 */
//Behaviour
//- latched two-step access only for wide elements in 16-bit bus mode
//- 16-bit read at bit1 set latches 32 bits, returns low half
//- next read at bit1 clear returns latched upper half
//- 16-bit write at bit1 set only latches low half
//- next write at bit1 clear commits upper bus half plus latched low
//- control bit 12 sends zero-quantum pause at next transmitter idle
//- control bit 11 sends pause with programmed quantum at next idle
//- back pressure in half duplex forces collision on received packets
//- control bit 7 makes statistics counters host-writable
//- control bit 6 increments all statistics counters once
//- control bit 5 clears all statistics counters
//- management port disabled: data line floats, clock held low
//- clearing transmit enable halts and flushes transmitter at once
//- receive enable bit gates reception immediately
//- control bits 31 to 13 read zero, writes ignored
//- MAC registers decoded at base 0x72000 with fixed offsets
//- full duplex ignores collisions, so back pressure needs half duplex
`timescale 1ns/1ps
`default_nettype none
module mac_control_host (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        H_MODE16,
    input  wire logic        H_WE,
    input  wire logic        H_RE,
    input  wire logic [19:0] H_AD,
    input  wire logic [31:0] H_WD,
    output logic [31:0]      H_RDATA,
    output logic             H_RVALID,
    input  wire logic        TX_IDLE,
    input  wire logic        RX_ACTIVE,
    input  wire logic        EV_TX_UNDERRUN,
    input  wire logic        EV_RETRY_LIMIT,
    input  wire logic        EV_COLLISION,
    input  wire logic        EV_PAUSE_RXD,
    input  wire logic        EV_PAUSE_TIME_ZERO,
    input  wire logic [15:0] PAUSE_TIME_VALUE,
    input  wire logic [31:0] SMII_STATUS,
    input  wire logic        MDIO_IN,
    output logic             TX_ENABLE,
    output logic             RX_ENABLE,
    output logic             TX_FLUSH,
    output logic             PAUSE_SEND,
    output logic             PAUSE_ZERO_QUANTUM,
    output logic [15:0]      PAUSE_QUANTUM,
    output logic             FORCE_COLLISION,
    output logic             FULL_DUPLEX,
    output logic             STATS_WRITE_EN,
    output logic             STATS_INCREMENT,
    output logic             STATS_CLEAR,
    output logic [47:0]      STATION_ADDR,
    output logic             MDC,
    output logic             MDIO_OUT,
    output logic             MDIO_OE
);
    logic [1:0]  mode_sync_reg;
    logic [1:0]  mdio_sync_reg;
    logic [31:0] ctl_reg;
    logic [31:0] cfg_reg;
    logic [31:0] txs_reg;
    logic [13:0] irq_stat_reg;
    logic [13:0] irq_mask_reg;
    logic [31:0] addr_lo_reg;
    logic [15:0] addr_hi_reg;
    logic [15:0] pause_q_reg;
    logic        pause_pend_reg;
    logic        pause_zero_reg;
    logic        send_reg;
    logic        send_zero_reg;
    logic        flush_reg;
    logic        inc_reg;
    logic        clr_reg;
    logic        force_col_reg;
    logic [31:0] rdata_reg;
    logic        rvalid_reg;
    mac_host_pkg::mgmt_state_t mg_state_reg;
    logic [31:0] shift_reg;
    logic [7:0]  div_cnt_reg;
    logic [5:0]  bit_cnt_reg;
    logic        sample_reg;
    logic        mdc_reg;
    logic        oe_reg;
    logic        mg_done_reg;
    mac_host_pkg::host_req_t req;
    mac_host_pkg::reg_acc_t  acc;
    wire         mode16;
    wire         mdio_s;
    wire         in_page;
    wire         wide;
    wire [31:0]  rd_full;
    wire [31:0]  rd_bus;
    wire         wr_ctl;
    wire         wr_cfg;
    wire         wr_txs;
    wire         wr_irq;
    wire         wr_en_set;
    wire         wr_en_clr;
    wire         wr_phy;
    wire         wr_alo;
    wire         wr_ahi;
    wire         wr_pq;
    wire         rd_irq;
    wire [13:0]  irq_events;
    wire [31:0]  txs_events;
    wire         mg_busy;
    wire         mg_en;
    wire [7:0]  half_period;
    wire         div_tick;
    wire         phy_is_read;
    assign mode16 = mode_sync_reg[1];
    assign mdio_s = mdio_sync_reg[1];
    assign in_page   = (H_AD[19:8] == mac_host_pkg::MAC_BASE_PAGE);
    assign req.wr    = H_WE & in_page;
    assign req.rd    = H_RE & in_page;
    assign req.addr  = H_AD;
    assign req.wdata = H_WD;
    assign wide = (acc.off == mac_host_pkg::OFF_CONFIG)
                | (acc.off == mac_host_pkg::OFF_PHY_SHIFT)
                | (acc.off == mac_host_pkg::OFF_ADDR_LOW)
                | (acc.off == mac_host_pkg::OFF_SMII_STATUS);
    half_word_access u_half (
        .clk        (CLK),
        .rst_n      (RST_N),
        .mode16     (mode16),
        .wide       (wide),
        .req        (req),
        .rdata_full (rd_full),
        .acc        (acc),
        .rdata_bus  (rd_bus)
    );
    assign wr_ctl    = acc.wr & (acc.off == mac_host_pkg::OFF_CONTROL);
    assign wr_cfg    = acc.wr & (acc.off == mac_host_pkg::OFF_CONFIG);
    assign wr_txs    = acc.wr & (acc.off == mac_host_pkg::OFF_TX_STATUS);
    assign wr_irq    = acc.wr & (acc.off == mac_host_pkg::OFF_IRQ_STATUS);
    assign wr_en_set = acc.wr & (acc.off == mac_host_pkg::OFF_IRQ_EN_SET);
    assign wr_en_clr = acc.wr & (acc.off == mac_host_pkg::OFF_IRQ_EN_CLR);
    assign wr_phy    = acc.wr & (acc.off == mac_host_pkg::OFF_PHY_SHIFT);
    assign wr_alo    = acc.wr & (acc.off == mac_host_pkg::OFF_ADDR_LOW);
    assign wr_ahi    = acc.wr & (acc.off == mac_host_pkg::OFF_ADDR_HIGH);
    assign wr_pq     = acc.wr & (acc.off == mac_host_pkg::OFF_PAUSE_QUANT);
    assign rd_irq    = acc.rd & (acc.off == mac_host_pkg::OFF_IRQ_STATUS);
    // stored control bits only, upper bits read zero
    assign rd_full =
        (acc.off == mac_host_pkg::OFF_CONTROL)     ? ctl_reg :
        (acc.off == mac_host_pkg::OFF_CONFIG)      ? cfg_reg :
        (acc.off == mac_host_pkg::OFF_LINK_STATUS) ?
            {29'h0, !mg_busy, 2'b00} :
        (acc.off == mac_host_pkg::OFF_TX_STATUS)   ? txs_reg :
        (acc.off == mac_host_pkg::OFF_IRQ_STATUS)  ? {18'h0, irq_stat_reg} :
        (acc.off == mac_host_pkg::OFF_IRQ_MASK)    ? {18'h0, irq_mask_reg} :
        (acc.off == mac_host_pkg::OFF_PHY_SHIFT)   ? shift_reg :
        (acc.off == mac_host_pkg::OFF_PAUSE_TIMER) ? {16'h0, PAUSE_TIME_VALUE} :
        (acc.off == mac_host_pkg::OFF_ADDR_LOW)    ? addr_lo_reg :
        (acc.off == mac_host_pkg::OFF_ADDR_HIGH)   ? {16'h0, addr_hi_reg} :
        (acc.off == mac_host_pkg::OFF_PAUSE_QUANT) ? {16'h0, pause_q_reg} :
        (acc.off == mac_host_pkg::OFF_SMII_STATUS) ? SMII_STATUS : 32'h0000_0000;
    // events set status only while unmasked
    assign irq_events = ({EV_PAUSE_TIME_ZERO, EV_PAUSE_RXD, 6'h00,
                          EV_RETRY_LIMIT, EV_TX_UNDERRUN, 3'h0, mg_done_reg}
                         & ~irq_mask_reg) & mac_host_pkg::IRQ_BITS;
    assign txs_events = {25'h0, EV_TX_UNDERRUN, 3'h0, EV_RETRY_LIMIT,
                         EV_COLLISION, 1'b0};
    assign mg_busy     = (mg_state_reg == mac_host_pkg::MG_SHIFT);
    assign mg_en       = ctl_reg[mac_host_pkg::CTL_MGMT_EN];
    assign half_period = mac_host_pkg::MDC_HALF_BASE << cfg_reg[mac_host_pkg::CFG_MDC_LO +: 2];
    assign div_tick    = (div_cnt_reg == half_period - 8'h01);
    assign phy_is_read = (shift_reg[29:28] == mac_host_pkg::PHY_OP_READ);
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode_sync_reg <= 2'h0;
            mdio_sync_reg <= 2'h0;
        end else begin
            mode_sync_reg <= {mode_sync_reg[0], H_MODE16};
            mdio_sync_reg <= {mdio_sync_reg[0], MDIO_IN};
        end
    end
    // register file
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctl_reg      <= mac_host_pkg::CTL_RESET;
            cfg_reg      <= mac_host_pkg::CFG_RESET;
            txs_reg      <= 32'h0000_0000;
            irq_stat_reg <= 14'h0000;
            irq_mask_reg <= mac_host_pkg::IRQ_MASK_RESET;
            addr_lo_reg  <= 32'h0000_0000;
            addr_hi_reg  <= 16'h0000;
            pause_q_reg  <= 16'h0000;
        end else begin
            // only the level bits are kept
            if (wr_ctl) ctl_reg <= acc.wdata & mac_host_pkg::CTL_STORED_MASK;
            if (wr_cfg) cfg_reg <= acc.wdata & mac_host_pkg::CFG_MASK;
            txs_reg <= ((wr_txs ? txs_reg & ~acc.wdata : txs_reg) | txs_events)
                       & mac_host_pkg::TXS_MASK;
            irq_stat_reg <= (wr_irq ? acc.wdata[13:0] & mac_host_pkg::IRQ_BITS :
                             rd_irq ? 14'h0000 : irq_stat_reg) | irq_events;
            if (wr_en_set || wr_en_clr)
                irq_mask_reg <= (irq_mask_reg
                                 & ~(wr_en_set ? acc.wdata[13:0] : 14'h0000))
                                | (wr_en_clr ? acc.wdata[13:0] & mac_host_pkg::IRQ_BITS
                                             : 14'h0000);
            if (wr_alo) addr_lo_reg <= acc.wdata;
            if (wr_ahi) addr_hi_reg <= acc.wdata[15:0];
            if (wr_pq) pause_q_reg <= acc.wdata[15:0];
        end
    end
    // command pulses and pause scheduling
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pause_pend_reg <= 1'b0;
            pause_zero_reg <= 1'b0;
            send_reg       <= 1'b0;
            send_zero_reg  <= 1'b0;
            flush_reg      <= 1'b0;
            inc_reg        <= 1'b0;
            clr_reg        <= 1'b0;
            force_col_reg  <= 1'b0;
        end else begin
            if (wr_ctl && (acc.wdata[mac_host_pkg::CTL_ZERO_PAUSE]
                           || acc.wdata[mac_host_pkg::CTL_PAUSE])) begin
                pause_pend_reg <= 1'b1;
                pause_zero_reg <= acc.wdata[mac_host_pkg::CTL_ZERO_PAUSE];
            end else if (pause_pend_reg && TX_IDLE) begin
                pause_pend_reg <= 1'b0;
            end
            send_reg      <= pause_pend_reg & TX_IDLE;
            send_zero_reg <= (pause_pend_reg & TX_IDLE) ? pause_zero_reg : send_zero_reg;
            flush_reg <= wr_ctl & ctl_reg[mac_host_pkg::CTL_TX_EN]
                         & ~acc.wdata[mac_host_pkg::CTL_TX_EN];
            inc_reg <= wr_ctl & acc.wdata[mac_host_pkg::CTL_STATS_INC];
            clr_reg <= wr_ctl & acc.wdata[mac_host_pkg::CTL_STATS_CLR];
            force_col_reg <= ctl_reg[mac_host_pkg::CTL_BACKPRESS]
                             & ~cfg_reg[mac_host_pkg::CFG_FULL_DUPLEX] & RX_ACTIVE;
        end
    end
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_reg  <= 32'h0000_0000;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= H_RE;
            if (H_RE) rdata_reg <= in_page ? rd_bus : 32'h0000_0000;
        end
    end
    // management shift engine, MSB out, LSB in
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mg_state_reg <= mac_host_pkg::MG_IDLE;
            shift_reg    <= 32'h0000_0000;
            div_cnt_reg  <= 8'h00;
            bit_cnt_reg  <= 6'h00;
            sample_reg   <= 1'b0;
            mdc_reg      <= 1'b0;
            oe_reg       <= 1'b0;
            mg_done_reg  <= 1'b0;
        end else begin
            mg_done_reg <= 1'b0;
            unique case (mg_state_reg)
                mac_host_pkg::MG_IDLE: begin
                    mdc_reg <= 1'b0;
                    oe_reg  <= 1'b0;
                    if (wr_phy) begin
                        shift_reg    <= acc.wdata;
                        div_cnt_reg  <= 8'h00;
                        bit_cnt_reg  <= 6'h00;
                        mg_state_reg <= mac_host_pkg::MG_SHIFT;
                    end
                end
                mac_host_pkg::MG_SHIFT: begin
                    // disabled port: clock low, line released
                    if (!mg_en) begin
                        mdc_reg <= 1'b0;
                        oe_reg  <= 1'b0;
                    end else begin
                        oe_reg <= ~(phy_is_read && bit_cnt_reg >= mac_host_pkg::PHY_TURN_BIT);
                        div_cnt_reg <= div_tick ? 8'h00 : div_cnt_reg + 8'h01;
                        if (div_tick) begin
                            mdc_reg <= ~mdc_reg;
                            if (!mdc_reg) begin
                                sample_reg <= mdio_s;
                            end else begin
                                shift_reg   <= {shift_reg[30:0], sample_reg};
                                bit_cnt_reg <= bit_cnt_reg + 6'h01;
                                if (bit_cnt_reg == mac_host_pkg::PHY_LAST_BIT) begin
                                    mg_done_reg  <= 1'b1;
                                    oe_reg       <= 1'b0;
                                    mg_state_reg <= mac_host_pkg::MG_IDLE;
                                end
                            end
                        end
                    end
                end
            endcase
        end
    end

    assign H_RDATA            = rdata_reg;
    assign H_RVALID           = rvalid_reg;
    assign TX_ENABLE          = ctl_reg[mac_host_pkg::CTL_TX_EN];
    assign RX_ENABLE          = ctl_reg[mac_host_pkg::CTL_RX_EN];
    assign TX_FLUSH           = flush_reg;
    assign PAUSE_SEND         = send_reg;
    assign PAUSE_ZERO_QUANTUM = send_zero_reg;
    assign PAUSE_QUANTUM      = pause_q_reg;
    assign FORCE_COLLISION    = force_col_reg;
    assign FULL_DUPLEX        = cfg_reg[mac_host_pkg::CFG_FULL_DUPLEX];
    assign STATS_WRITE_EN     = ctl_reg[mac_host_pkg::CTL_STATS_WE];
    assign STATS_INCREMENT    = inc_reg;
    assign STATS_CLEAR        = clr_reg;
    assign STATION_ADDR       = {addr_hi_reg, addr_lo_reg};
    // clock low and line floating when disabled
    assign MDC                = mdc_reg;
    assign MDIO_OUT           = shift_reg[31];
    assign MDIO_OE            = oe_reg;
endmodule // mac_control_host
`default_nettype wire

// [verification/host_cpu_model.sv]
/* Host processor model on the parallel register bus.
   Assumes strobes are taken at the rising CLK edge. */
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
    input  wire logic        CLK,
    input  wire logic [31:0] H_RDATA,
    input  wire logic        H_RVALID,
    output logic             H_WE,
    output logic             H_RE,
    output logic [19:0]      H_AD,
    output logic [31:0]      H_WD
);
    initial {H_WE, H_RE, H_AD, H_WD} = '0;
    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        @(posedge CLK);
        {H_WE, H_AD, H_WD} <= {1'h1, a, d};
        @(posedge CLK);
        {H_WE, H_AD, H_WD} <= {1'h0, ~a, ~d};
        #1;
    endtask
    task automatic rd(input logic [19:0] a, output logic [31:0] d, output logic v);
        @(posedge CLK);
        {H_RE, H_AD} <= {1'h1, a};
        @(posedge CLK);
        {H_RE, H_AD} <= {1'h0, ~a};
        #1;
        {v, d} = {H_RVALID, H_RDATA};
    endtask
    task automatic enable_mac();
        wr(20'h72000, 32'h0000_000C);
    endtask
endmodule // host_cpu_model
`default_nettype wire

// [verification/mac_control_host_sva.sv]
/* Port checker for the MAC control block.
   Assumes it is bound to mac_control_host, one clock, async reset. */
`timescale 1ns/1ps
`default_nettype none
module mac_control_host_sva (
    input wire logic        CLK,
    input wire logic        RST_N,
    input wire logic        H_MODE16,
    input wire logic        H_WE,
    input wire logic [19:0] H_AD,
    input wire logic [31:0] H_WD,
    input wire logic        TX_IDLE,
    input wire logic        RX_ACTIVE,
    input wire logic        TX_ENABLE,
    input wire logic        TX_FLUSH,
    input wire logic        PAUSE_SEND,
    input wire logic        FORCE_COLLISION,
    input wire logic        FULL_DUPLEX,
    input wire logic        STATS_CLEAR,
    input wire logic [47:0] STATION_ADDR
);
    default clocking dc @(posedge CLK); endclocking
    default disable iff (!RST_N);
    wire ctl_wr  = H_WE && H_AD[19:2] == 18'h1C800;
    wire adr_wr  = H_WE && H_AD[19:2] == 18'h1C826;
    wire clr_cmd = ctl_wr && H_WD[5];
    a_tx_enable_follow: assert property (ctl_wr |=> TX_ENABLE == $past(H_WD[3]))
        else $error("transmit enable not taken from control write");
    a_flush_on_stop: assert property (TX_FLUSH |-> !TX_ENABLE && $past(TX_ENABLE))
        else $error("flush without transmit stop");
    a_clear_cause: assert property (STATS_CLEAR |-> $past(clr_cmd))
        else $error("statistics clear without command");
    a_pause_at_idle: assert property (PAUSE_SEND |-> $past(TX_IDLE))
        else $error("pause sent while transmitter busy");
    a_collide_half: assert property (FORCE_COLLISION |-> $past(RX_ACTIVE) && !$past(FULL_DUPLEX))
        else $error("collision forced outside half duplex receive");
    a_wide_low_held: assert property (adr_wr && H_MODE16 && H_AD[1] |=> $stable(STATION_ADDR))
        else $error("first half write changed the register");
    a_wide_commit: assert property (adr_wr && H_MODE16 && !H_AD[1] |=> STATION_ADDR[31:16] == $past(H_WD[15:0]))
        else $error("second half write did not commit upper half");
    a_wide_direct: assert property (adr_wr && !H_MODE16 |=> STATION_ADDR[31:0] == $past(H_WD))
        else $error("32-bit write not stored directly");
endmodule // mac_control_host_sva
`default_nettype wire

// [verification/tb_mac_control_host.sv]
/* Self-checking bench for the MAC control block.
   Assumes a 25 MHz clock and the host model on the bus. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb_mac_control_host;
    logic        CLK = 1'h0, RST_N = 1'h0, H_MODE16 = 1'h0, H_WE, H_RE, H_RVALID, ok;
    logic [19:0] H_AD;
    logic [31:0] H_WD, H_RDATA, d, v, seed = 32'hFDE5, SMII_STATUS = 32'h0;
    logic [15:0] PAUSE_TIME_VALUE = 16'h1234, PAUSE_QUANTUM;
    logic [47:0] STATION_ADDR;
    logic [7:0]  ev = 8'h0;
    logic        TX_ENABLE, RX_ENABLE, TX_FLUSH, PAUSE_SEND, PAUSE_ZERO_QUANTUM, FULL_DUPLEX;
    logic        FORCE_COLLISION, STATS_WRITE_EN, STATS_INCREMENT, STATS_CLEAR;
    logic        MDC, MDIO_OUT, MDIO_OE;
    int          fail_count = 0, samples_checked = 0, cyc = 0;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic report_and_stop();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    mac_control_host u_mac_control_host (.*, .TX_IDLE(ev[7]), .RX_ACTIVE(ev[6]),
        .EV_TX_UNDERRUN(ev[5]), .EV_RETRY_LIMIT(ev[4]), .EV_COLLISION(ev[3]),
        .EV_PAUSE_RXD(ev[2]), .EV_PAUSE_TIME_ZERO(ev[1]), .MDIO_IN(ev[0]));
    host_cpu_model u_host_cpu_model (.*);
    initial forever #20 CLK = ~CLK;
    always @(posedge CLK) begin
        ev <= 8'(rnd());
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            report_and_stop();
        end
    end
    initial begin
        repeat (16) @(posedge CLK);
        RST_N <= 1'h1;
        u_host_cpu_model.rd(20'h72004, d, ok);
        `CHK("config", 32'h0000_0800, d)
        u_host_cpu_model.rd(20'h72038, d, ok);
        `CHK("pause time", 32'h0000_1234, d)
        u_host_cpu_model.rd(20'h70004, d, ok);
        `CHK("off page", 33'h1_0000_0000, {ok, d})
        for (int i = 0; i < 10; i++) begin
            v = rnd();
            u_host_cpu_model.wr(20'h72004, v);
            `CHK("duplex", v[1], FULL_DUPLEX)
            u_host_cpu_model.wr(20'h72000, v);
            `CHK("receive", v[2], RX_ENABLE)
            `CHK("flush", d[3] & ~v[3], TX_FLUSH)
            `CHK("stats en", v[7], STATS_WRITE_EN)
            `CHK("stats cmd", v[6:5], {STATS_INCREMENT, STATS_CLEAR})
            `CHK("mgmt off", 2'h0, {MDC, MDIO_OE} & {2{~v[4]}})
            u_host_cpu_model.rd(20'h72000, d, ok);
            `CHK("control", v & 32'h0000_019C, d)
        end
        u_host_cpu_model.wr(20'h72000, 32'h0000_0000);
        u_host_cpu_model.wr(20'h72028, 32'h0000_0001);
        u_host_cpu_model.wr(20'h72034, 32'h5000_0000);
        u_host_cpu_model.rd(20'h72008, d, ok);
        `CHK("mgmt busy", 32'h0, d)
        repeat (40) begin
            @(posedge CLK);
            #1;
            `CHK("mgmt held", 2'h0, {MDC, MDIO_OE})
        end
        u_host_cpu_model.wr(20'h72000, 32'h0000_0010);
        @(posedge CLK);
        #1;
        `CHK("mgmt on", 2'h2, {MDIO_OE, MDIO_OUT})
        repeat (2100) @(posedge CLK);
        u_host_cpu_model.rd(20'h72008, d, ok);
        `CHK("mgmt idle", 32'h4, d)
        u_host_cpu_model.rd(20'h72024, d, ok);
        `CHK("mgmt irq", 32'h1, d)
        u_host_cpu_model.enable_mac();
        `CHK("transmit", 1'h1, TX_ENABLE)
        v = rnd();
        u_host_cpu_model.wr(20'h720BC, v);
        `CHK("quantum", v[15:0], PAUSE_QUANTUM)
        for (int k = 11; k < 13; k++) begin
            repeat (20) @(posedge CLK);
            u_host_cpu_model.wr(20'h72000, 32'h1 << k);
            for (int n = 0; n < 60 && PAUSE_SEND !== 1'h1; n++) begin
                @(posedge CLK);
                #1;
            end
            `CHK("pause", 2'({1'h1, k == 12}), {PAUSE_SEND, PAUSE_ZERO_QUANTUM})
        end
        u_host_cpu_model.wr(20'h72098, v);
        `CHK("addr direct", v, STATION_ADDR[31:0])
        @(posedge CLK);
        H_MODE16 <= 1'h1;
        repeat (4) @(posedge CLK);
        d = ~v;
        u_host_cpu_model.wr(20'h7209A, {16'h0, d[15:0]});
        `CHK("addr held", v, STATION_ADDR[31:0])
        u_host_cpu_model.wr(20'h72098, {16'h0, d[31:16]});
        `CHK("addr commit", d, STATION_ADDR[31:0])
        u_host_cpu_model.rd(20'h7209A, v, ok);
        `CHK("read low", {16'h0, d[15:0]}, v)
        u_host_cpu_model.rd(20'h72098, v, ok);
        `CHK("read high", {16'h0, d[31:16]}, v)
        report_and_stop();
    end
endmodule // tb_mac_control_host
bind mac_control_host mac_control_host_sva u_mac_control_host_sva (.*);
`default_nettype wire
